// File: verilog/mon_regs_pkg.sv
package mon_regs_pkg;

	// ------------------------------------------------------------
	// Register offsets on the internal register port.
	// ------------------------------------------------------------
	localparam logic [7:0] OFS_ALERT_MASK_SECOND = 8'h75;
	localparam logic [7:0] OFS_LOW_BITS_VOLTAGE = 8'h76;
	localparam logic [7:0] OFS_LOW_BITS_TEMP_TWELVE = 8'h77;
	localparam logic [7:0] OFS_PIN_AND_TACH_CONFIG = 8'h78;

	// ------------------------------------------------------------
	// Values after reset.
	// ------------------------------------------------------------
	localparam logic [7:0] RST_ALERT_MASK_SECOND = 8'h00;
	localparam logic [7:0] RST_LOW_BITS = 8'h00;
	localparam logic [7:0] RST_PIN_AND_TACH_CONFIG = 8'h00;

	// ------------------------------------------------------------
	// Field positions.
	// ------------------------------------------------------------
	// Mask register, one bit per status flag of the second group.
	localparam int MSK_TWELVE_VOLT_VID = 0;
	localparam int MSK_OVERHEAT = 1;
	localparam int MSK_FAN_ONE = 2;
	localparam int MSK_FAN_TWO = 3;
	localparam int MSK_FAN_THREE = 4;
	localparam int MSK_SHARED_PIN = 5;
	localparam int MSK_REMOTE_ONE = 6;
	localparam int MSK_REMOTE_TWO = 7;
	// Configuration register.
	localparam int CFG_ALERT_ON_FAN_PIN = 0;
	localparam int CFG_OVERHEAT_OR_VOLT = 1;
	localparam int CFG_BOOST = 2;
	localparam int CFG_FAST_TACH = 3;
	localparam int CFG_STEADY_TACH_LO = 4;
	localparam int CFG_STEADY_TACH_HI = 7;

	// Input synchroniser depth for pins.
	localparam int PIN_SYNC_STAGES = 3;

	// Reading width and the part that sits in the low-bits registers.
	localparam int READING_BITS = 10;
	localparam int LOW_BITS_PER_READING = 2;

	// Role of the multi-function pin.
	typedef enum logic [1:0] {
		SEL_FAN_FOUR_TACH = 2'h0,
		SEL_OVERHEAT = 2'h1,
		SEL_ALERT = 2'h2,
		SEL_GENERAL_IO = 2'h3
	} shared_pin_selector_t;

	// One request from the serial interface to the register file.
	typedef struct packed {
		logic wr;
		logic rd;
		logic [7:0] addr;
		logic [7:0] wdata;
	} reg_req_t;

	// Pin roles that the rest of the device follows.
	typedef struct packed {
		logic alert_on_fan_pin;
		logic alert_on_shared_pin;
		logic overheat_on_dedicated_pin;
		logic overheat_on_shared_pin;
		logic volt_measure_on_dedicated_pin;
	} pin_roles_t;

endpackage : mon_regs_pkg

// File: verilog/reading_freeze.sv
module reading_freeze
	import mon_regs_pkg::*;
#(
	parameter int CHANNELS = 4
) (
	// Clock and reset.
	input wire logic clk_sys_in,
	input wire logic rst_in,
	// Live readings from the converter, channel 0 in the low bits.
	input wire logic [CHANNELS*READING_BITS-1:0] reading_in,
	// Host reads of the low-bits register and of each upper byte.
	input wire logic low_read_in,
	input wire logic [CHANNELS-1:0] high_read_in,
	// Held values and freeze state.
	output logic [CHANNELS*LOW_BITS_PER_READING-1:0] low_bits_out,
	output logic [CHANNELS*8-1:0] high_bytes_out,
	output logic frozen_out
);

	logic [CHANNELS-1:0] pending;
	logic [CHANNELS-1:0] next_pending;
	logic [CHANNELS*LOW_BITS_PER_READING-1:0] next_low;
	logic [CHANNELS*8-1:0] next_high;
	logic [CHANNELS*LOW_BITS_PER_READING-1:0] live_low;
	logic [CHANNELS*8-1:0] live_high;

	// ------------------------------------------------------------
	// Split each live reading into its upper byte and low bits.
	// ------------------------------------------------------------
	for (genvar ch = 0; ch < CHANNELS; ch++) begin : g_split
		assign live_low[ch*2 +: 2] = reading_in[ch*READING_BITS +: 2];
		assign live_high[ch*8 +: 8] = reading_in[ch*READING_BITS+2 +: 8];
	end

	// Track live data until the low bits are read, then hold every
	// channel until each upper byte has been read once, so the host
	// never pairs halves of two different conversions.
	always_comb begin
		next_pending = pending & ~high_read_in;
		next_low = low_bits_out;
		next_high = high_bytes_out;
		if (low_read_in) begin
			next_pending = '1;
		end
		if (pending == '0 && !low_read_in) begin
			next_low = live_low;
			next_high = live_high;
		end
	end

	// Register the held data and the outstanding reads.
	always_ff @(posedge clk_sys_in or posedge rst_in) begin
		if (rst_in) begin
			pending <= '0;
			low_bits_out <= '0;
			high_bytes_out <= '0;
			frozen_out <= 1'b0;
		end else begin
			pending <= next_pending;
			low_bits_out <= next_low;
			high_bytes_out <= next_high;
			frozen_out <= next_pending != '0;
		end
	end

endmodule : reading_freeze

// File: verilog/alert_mask_and_fan_config_regs.sv
// How it works
// - Mask bit 0 hides twelve-volt limit alerts while the pin reads 12 V.
// - Mask bit 0 hides code-change alerts while the pin is id bit five.
// - Mask bit 1 keeps overheat events from raising the alert.
// - Mask bits 2, 3, 4 hide fan one, two, three faults.
// - Mask bit 5 hides fan four faults when shared pin is tachometer.
// - Mask bit 5 hides overheat timer limit alerts when pin is thermal.
// - Mask bit 5 hides general input assertion alerts when pin is io.
// - Mask bit 6 hides remote diode one open or short alerts.
// - Mask bit 7 hides remote diode two open or short alerts.
// - First low-bits register returns 2.5 V, core, main, 5 V bits.
// - Second low-bits register returns 12 V and three temperature bits.
// - Reading low bits freezes them and upper bytes until those are read.
// - Config bit 0 turns second fan-drive pin into the alert output.
// - Config bit 1 picks 2.5 V or overheat on the dedicated pin; it stays 2.5 V while the shared pin is overheat.
// - The overheat signal can be timed while it stays asserted.
// - Config bit 2 runs all fans at full duty on overheat input.
// - Config bit 3 raises the tachometer update rate.
// - Config bits 4 to 7 make tach one to four continuous, no stretch.
// - With the lock bit set the configuration register ignores writes.
module alert_mask_and_fan_config_regs
	import mon_regs_pkg::*;
(
	// Clock and reset.
	input wire logic clk_sys_in,
	input wire logic rst_in,
	// Register requests from the serial interface.
	input wire reg_req_t reg_req_in,
	output logic [7:0] reg_rdata_out,
	output logic reg_rvalid_out,
	// Device state feeding this slice.
	input wire logic [7:0] status_flags_in,
	input wire logic [4*READING_BITS-1:0] volt_readings_in,
	input wire logic [4*READING_BITS-1:0] temp_twelve_readings_in,
	input wire logic [7:0] high_byte_read_in,
	input wire logic [1:0] shared_pin_selector_in,
	input wire logic lock_in,
	input wire logic overheat_signal_in,
	// Held upper bytes for the result registers.
	output logic [4*8-1:0] volt_high_bytes_out,
	output logic [4*8-1:0] temp_twelve_high_bytes_out,
	// Alert and pin roles.
	output logic alert_out,
	output pin_roles_t pin_roles_out,
	// Fan and tachometer control.
	output logic fans_full_duty_out,
	output logic overheat_timing_out,
	output logic fast_tach_out,
	output logic [3:0] steady_tach_out
);

	// ------------------------------------------------------------
	// Register state.
	// ------------------------------------------------------------
	logic [7:0] alert_mask_second;
	logic [7:0] pin_and_tach_config;
	logic [7:0] next_alert_mask_second;
	logic [7:0] next_pin_and_tach_config;
	logic [7:0] next_rdata;
	logic [7:0] low_bits_voltage;
	logic [7:0] low_bits_temp_twelve;
	logic volt_frozen;
	logic temp_frozen;
	logic rd_volt;
	logic rd_temp;

	assign rd_volt = reg_req_in.rd && reg_req_in.addr == OFS_LOW_BITS_VOLTAGE;
	assign rd_temp = reg_req_in.rd
		&& reg_req_in.addr == OFS_LOW_BITS_TEMP_TWELVE;

	// Host writes. The configuration register is frozen by the global lock;
	// the mask is not, so alerts can still be tuned in a locked system.
	always_comb begin
		next_alert_mask_second = alert_mask_second;
		next_pin_and_tach_config = pin_and_tach_config;
		if (reg_req_in.wr) begin
			if (reg_req_in.addr == OFS_ALERT_MASK_SECOND) begin
				next_alert_mask_second = reg_req_in.wdata;
			end
			if (reg_req_in.addr == OFS_PIN_AND_TACH_CONFIG && !lock_in) begin
				next_pin_and_tach_config = reg_req_in.wdata;
			end
		end
	end

	// Read mux; unmapped offsets read zero.
	always_comb begin
		unique case (reg_req_in.addr)
			OFS_ALERT_MASK_SECOND: next_rdata = alert_mask_second;
			OFS_LOW_BITS_VOLTAGE: next_rdata = low_bits_voltage;
			OFS_LOW_BITS_TEMP_TWELVE: next_rdata = low_bits_temp_twelve;
			OFS_PIN_AND_TACH_CONFIG: next_rdata = pin_and_tach_config;
			default: next_rdata = 8'h00;
		endcase
	end

	// Register writable state and the read answer.
	always_ff @(posedge clk_sys_in or posedge rst_in) begin
		if (rst_in) begin
			alert_mask_second <= RST_ALERT_MASK_SECOND;
			pin_and_tach_config <= RST_PIN_AND_TACH_CONFIG;
			reg_rdata_out <= 8'h00;
			reg_rvalid_out <= 1'b0;
		end else begin
			alert_mask_second <= next_alert_mask_second;
			pin_and_tach_config <= next_pin_and_tach_config;
			reg_rdata_out <= reg_req_in.rd ? next_rdata : 8'h00;
			reg_rvalid_out <= reg_req_in.rd;
		end
	end

	// ------------------------------------------------------------
	// Low-bits registers with freeze on read.
	// ------------------------------------------------------------
	reading_freeze #(
		.CHANNELS(4)
	) u_freeze_volt (
		.clk_sys_in(clk_sys_in),
		.rst_in(rst_in),
		.reading_in(volt_readings_in),
		.low_read_in(rd_volt),
		.high_read_in(high_byte_read_in[3:0]),
		.low_bits_out(low_bits_voltage),
		.high_bytes_out(volt_high_bytes_out),
		.frozen_out(volt_frozen)
	);

	reading_freeze #(
		.CHANNELS(4)
	) u_freeze_temp (
		.clk_sys_in(clk_sys_in),
		.rst_in(rst_in),
		.reading_in(temp_twelve_readings_in),
		.low_read_in(rd_temp),
		.high_read_in(high_byte_read_in[7:4]),
		.low_bits_out(low_bits_temp_twelve),
		.high_bytes_out(temp_twelve_high_bytes_out),
		.frozen_out(temp_frozen)
	);

	// ------------------------------------------------------------
	// Overheat pin synchroniser.
	// ------------------------------------------------------------
	logic [PIN_SYNC_STAGES-1:0] overheat_sync;
	logic overheat_level;
	logic next_overheat_level;

	// The level only changes once the last two stages agree, which
	// filters a one-cycle glitch at the cost of one more cycle of delay.
	always_comb begin
		next_overheat_level = overheat_level;
		if (overheat_sync[1] == overheat_sync[2]) begin
			next_overheat_level = overheat_sync[2];
		end
	end

	always_ff @(posedge clk_sys_in or posedge rst_in) begin
		if (rst_in) begin
			overheat_sync <= '0;
			overheat_level <= 1'b0;
		end else begin
			overheat_sync <= {overheat_sync[1:0], overheat_signal_in};
			overheat_level <= next_overheat_level;
		end
	end

	// ------------------------------------------------------------
	// Pin roles, alert and fan control.
	// ------------------------------------------------------------
	pin_roles_t next_roles;
	logic next_alert;
	logic next_full_duty;
	logic next_timing;
	logic overheat_is_input;
	logic [7:0] unmasked;

	// Masking gates only the alert; the status flags are never altered.
	// Bits 0 and 5 mean different events per pin role, but the mask
	// applies whichever event the flag currently carries.
	assign unmasked = status_flags_in & ~alert_mask_second;

	always_comb begin
		next_roles.alert_on_fan_pin =
			pin_and_tach_config[CFG_ALERT_ON_FAN_PIN];
		next_roles.alert_on_shared_pin =
			shared_pin_selector_in == SEL_ALERT;
		next_roles.overheat_on_shared_pin =
			shared_pin_selector_in == SEL_OVERHEAT;
		next_roles.overheat_on_dedicated_pin =
			pin_and_tach_config[CFG_OVERHEAT_OR_VOLT]
			&& shared_pin_selector_in != SEL_OVERHEAT;
		next_roles.volt_measure_on_dedicated_pin =
			!next_roles.overheat_on_dedicated_pin;
		overheat_is_input = next_roles.overheat_on_dedicated_pin
			|| next_roles.overheat_on_shared_pin;
		next_alert = |unmasked[MSK_TWELVE_VOLT_VID]
			|| unmasked[MSK_OVERHEAT]
			|| |unmasked[MSK_FAN_THREE:MSK_FAN_ONE]
			|| unmasked[MSK_SHARED_PIN]
			|| unmasked[MSK_REMOTE_ONE]
			|| unmasked[MSK_REMOTE_TWO];
		next_timing = overheat_is_input && overheat_level;
		next_full_duty = next_timing
			&& pin_and_tach_config[CFG_BOOST];
	end

	always_ff @(posedge clk_sys_in or posedge rst_in) begin
		if (rst_in) begin
			alert_out <= 1'b0;
			pin_roles_out <= '0;
			fans_full_duty_out <= 1'b0;
			overheat_timing_out <= 1'b0;
			fast_tach_out <= 1'b0;
			steady_tach_out <= 4'h0;
		end else begin
			alert_out <= next_alert;
			pin_roles_out <= next_roles;
			fans_full_duty_out <= next_full_duty;
			overheat_timing_out <= next_timing;
			fast_tach_out <= pin_and_tach_config[CFG_FAST_TACH];
			steady_tach_out <= pin_and_tach_config[
				CFG_STEADY_TACH_HI:CFG_STEADY_TACH_LO];
		end
	end

	// ------------------------------------------------------------
	// Assertions.
	// ------------------------------------------------------------
	default clocking cb @(posedge clk_sys_in);
	endclocking
	default disable iff (rst_in);

	a_alert_follows_mask: assert property (
		!$past(rst_in)
		|-> alert_out == $past(|(status_flags_in & ~alert_mask_second)))
		else $error("alert does not follow unmasked flags");
	a_mask_twelve: assert property (
		alert_mask_second[0] && status_flags_in == 8'h01 |=> !alert_out)
		else $error("masked twelve volt flag raised alert");
	a_mask_overheat: assert property (
		!alert_mask_second[1] && status_flags_in[1] |=> alert_out)
		else $error("unmasked overheat flag did not alert");
	a_mask_fans: assert property (
		alert_mask_second[4:2] == 3'h7 && status_flags_in == 8'h1C
		|=> !alert_out)
		else $error("masked fan fault raised alert");
	a_mask_shared: assert property (
		alert_mask_second[5] && status_flags_in == 8'h20 |=> !alert_out)
		else $error("masked shared pin fault raised alert");
	a_mask_diodes: assert property (
		alert_mask_second[7:6] == 2'h3 && status_flags_in == 8'hC0
		|=> !alert_out)
		else $error("masked diode fault raised alert");
	a_lock_holds: assert property (
		lock_in |=> $stable(pin_and_tach_config))
		else $error("locked configuration changed");
	a_freeze_holds: assert property (
		rd_volt ##1 !(|high_byte_read_in[3:0]) [*2]
		|-> $stable(low_bits_voltage) && volt_frozen)
		else $error("low bits changed while frozen");
	a_boost_needs_bit: assert property (
		fans_full_duty_out |-> $past(pin_and_tach_config[CFG_BOOST]))
		else $error("full duty without boost bit");
	a_dedicated_role: assert property (
		pin_roles_out.overheat_on_dedicated_pin
		|-> !pin_roles_out.overheat_on_shared_pin
		&& !pin_roles_out.volt_measure_on_dedicated_pin)
		else $error("overheat role on both pins");
	a_read_answer: assert property (
		reg_req_in.rd && reg_req_in.addr == OFS_LOW_BITS_VOLTAGE
		|=> reg_rvalid_out && reg_rdata_out == $past(low_bits_voltage))
		else $error("low bits read returned wrong data");
	a_temp_freeze: assert property (
		rd_temp ##1 !(|high_byte_read_in[7:4]) [*2]
		|-> $stable(low_bits_temp_twelve) && temp_frozen)
		else $error("temperature low bits changed while frozen");
	a_temp_answer: assert property (
		rd_temp |=> reg_rvalid_out
		&& reg_rdata_out == $past(low_bits_temp_twelve))
		else $error("second low bits read returned wrong data");

	// Pin roles and fan controls trail the register by one cycle, so the
	// rest of the device never sees a half-written configuration.
	a_fan_pin_alert: assert property (
		pin_roles_out.alert_on_fan_pin
		== $past(pin_and_tach_config[CFG_ALERT_ON_FAN_PIN]))
		else $error("fan pin role does not follow configuration");
	a_tach_copies: assert property (
		{steady_tach_out, fast_tach_out} == $past(
			pin_and_tach_config[CFG_STEADY_TACH_HI:CFG_FAST_TACH]))
		else $error("tachometer controls do not follow configuration");
	a_shared_alert: assert property (
		!$past(rst_in) |-> pin_roles_out.alert_on_shared_pin
		== ($past(shared_pin_selector_in) == SEL_ALERT))
		else $error("shared pin alert role does not follow selector");
	a_timing_level: assert property (
		overheat_timing_out |-> $past(overheat_level))
		else $error("overheat timing without overheat level");
	a_boost_role: assert property (
		fans_full_duty_out |-> overheat_timing_out)
		else $error("full duty without overheat input");

	c_alert_raised: cover property (!alert_out ##1 alert_out);
	c_freeze_release: cover property (volt_frozen ##1 !volt_frozen);
	c_boost: cover property (fans_full_duty_out);
	c_temp_frozen: cover property (temp_frozen);
	c_locked_write: cover property (lock_in && reg_req_in.wr);

endmodule : alert_mask_and_fan_config_regs

// File: tb/host_model.sv
module host_model
	import mon_regs_pkg::*;
(
	// Clock.
	input wire logic clk_sys_in,
	// Requests and upper-byte reads towards the register slice.
	output reg_req_t reg_req_out,
	output logic [7:0] high_byte_read_out
);
	timeunit 1ns;
	timeprecision 1ps;

	// Idle request at time zero.
	initial begin
		reg_req_out = {1'b0, 1'b0, 8'hAA, 8'h55};
		high_byte_read_out = 8'h00;
	end

	// One request, held for exactly one taking edge.
	task automatic send(input logic w, input logic [7:0] a,
		input logic [7:0] d);
		@(posedge clk_sys_in);
		#1;
		reg_req_out = {w, !w, a, d};
		@(posedge clk_sys_in);
		#1;
		// Idle address and data are scrambled so a stale latch shows.
		reg_req_out = {1'b0, 1'b0, ~a, ~d};
	endtask : send

	task automatic write_reg(input logic [7:0] a, input logic [7:0] d);
		send(1'b1, a, d);
	endtask : write_reg

	task automatic read_reg(input logic [7:0] a);
		send(1'b0, a, 8'h00);
	endtask : read_reg

	// Reads each selected upper byte in turn, which lifts the freeze.
	task automatic release_bytes(input logic [7:0] bits);
		for (int i = 0; i < 8; i++) begin
			if (bits[i]) begin
				@(posedge clk_sys_in);
				#1;
				high_byte_read_out = 8'h01 << i;
				@(posedge clk_sys_in);
				#1;
				high_byte_read_out = 8'h00;
			end
		end
	endtask : release_bytes
endmodule : host_model

// File: tb/tb.sv
module tb
	import mon_regs_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;

	logic clk_sys_in, rst_in, lock, overheat, alert, rvalid;
	logic full_duty, timing, fast;
	logic [3:0] steady;
	logic [1:0] sel;
	logic [7:0] rdata, status, hbr, m;
	logic [39:0] volt, temp, ra, rb;
	logic [31:0] volt_hi, temp_hi, rnd;
	reg_req_t req;
	pin_roles_t roles, ex;
	logic [7:0] exp_q[$];
	int err_total = 0;
	int checks_done = 0;
	int cycles = 0;

	host_model host_u (.clk_sys_in(clk_sys_in), .reg_req_out(req),
		.high_byte_read_out(hbr));
	alert_mask_and_fan_config_regs dut_u (.clk_sys_in(clk_sys_in),
		.rst_in(rst_in), .reg_req_in(req), .reg_rdata_out(rdata),
		.reg_rvalid_out(rvalid), .status_flags_in(status),
		.volt_readings_in(volt), .temp_twelve_readings_in(temp),
		.high_byte_read_in(hbr), .shared_pin_selector_in(sel),
		.lock_in(lock), .overheat_signal_in(overheat),
		.volt_high_bytes_out(volt_hi), .temp_twelve_high_bytes_out(temp_hi),
		.alert_out(alert), .pin_roles_out(roles),
		.fans_full_duty_out(full_duty), .overheat_timing_out(timing),
		.fast_tach_out(fast), .steady_tach_out(steady));

	// Clock at 100 MHz.
	initial begin
		clk_sys_in = 1'b0;
		forever #5 clk_sys_in = ~clk_sys_in;
	end

	task automatic chk(input string name, input logic [31:0] e,
		input logic [31:0] g);
		checks_done++;
		if (g !== e) begin
			err_total++;
			$display("wrong value %s expected %h seen %h", name, e, g);
		end
	endtask : chk

	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", checks_done, err_total);
		if (err_total == 0 && checks_done > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask : tally_and_finish

	// The whole run needs about 370 cycles; the ceiling leaves room.
	always @(posedge clk_sys_in) begin
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			err_total++;
			tally_and_finish();
		end
	end

	// Read results are matched, oldest first, against the noted values.
	always @(posedge clk_sys_in) begin
		if (rvalid === 1'b1) begin
			if (exp_q.size() == 0)
				chk("unexpected read", 32'h0, 32'h1);
			else
				chk("read data", 32'(exp_q.pop_front()), 32'(rdata));
		end
	end

	function automatic logic [31:0] lfsr(input logic [31:0] x);
		return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
	endfunction : lfsr

	function automatic logic [7:0] low_of(input logic [39:0] r);
		logic [7:0] v;
		for (int i = 0; i < 4; i++)
			v[2*i +: 2] = r[10*i +: 2];
		return v;
	endfunction : low_of

	function automatic logic [31:0] high_of(input logic [39:0] r);
		logic [31:0] v;
		for (int i = 0; i < 4; i++)
			v[8*i +: 8] = r[10*i+2 +: 8];
		return v;
	endfunction : high_of

	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		exp_q.push_back(e);
		host_u.read_reg(a);
	endtask : rd

	task automatic idle(input int n);
		repeat (n) @(posedge clk_sys_in);
		#1;
	endtask : idle

	task automatic new_val(output logic [39:0] r);
		rnd = lfsr(rnd);
		r[31:0] = rnd;
		rnd = lfsr(rnd);
		r[39:32] = rnd[7:0];
	endtask : new_val

	// Main sequence.
	initial begin
		rst_in = 1'b1;
		{status, volt, temp, sel, lock, overheat} = '0;
		rnd = 32'd88485;
		idle(10);
		rst_in = 1'b0;
		for (int a = 8'h75; a <= 8'h79; a++)
			rd(8'(a), 8'h00);
		host_u.release_bytes(8'hFF);
		host_u.write_reg(8'h76, 8'hFF);
		rd(8'h76, 8'h00);
		host_u.release_bytes(8'h0F);
		// Each flag alone, the fan and diode groups, then random flags
		// against random masks.
		for (int i = 0; i < 18; i++) begin
			rnd = lfsr(rnd);
			status = (i < 8) ? 8'h01 << i : rnd[7:0];
			if (i == 8) status = 8'h1C;
			if (i == 9) status = 8'hC0;
			m = (i < 10) ? ~status : rnd[15:8];
			host_u.write_reg(OFS_ALERT_MASK_SECOND, m);
			idle(3);
			chk("alert", 32'(|(status & ~m)), 32'(alert));
			if (i < 10) begin
				host_u.write_reg(OFS_ALERT_MASK_SECOND, status);
				idle(3);
				chk("masked", 32'h0, 32'(alert));
			end
		end
		// Freeze holds across new readings until the upper bytes are read.
		for (int k = 0; k < 2; k++) begin
			new_val(ra);
			if (k == 0) volt = ra; else temp = ra;
			idle(3);
			rd(8'h76 + 8'(k), low_of(ra));
			new_val(rb);
			if (k == 0) volt = rb; else temp = rb;
			idle(3);
			rd(8'h76 + 8'(k), low_of(ra));
			idle(2);
			chk("held high", high_of(ra), k ? temp_hi : volt_hi);
			host_u.release_bytes(k ? 8'hF0 : 8'h0F);
			idle(3);
			chk("live high", high_of(rb), k ? temp_hi : volt_hi);
			rd(8'h76 + 8'(k), low_of(rb));
			host_u.release_bytes(k ? 8'hF0 : 8'h0F);
		end
		// Pin roles for every selector and both low config bits.
		for (int c = 0; c < 4; c++) begin
			for (int s = 0; s < 4; s++) begin
				host_u.write_reg(OFS_PIN_AND_TACH_CONFIG, 8'(c));
				sel = 2'(s);
				idle(3);
				ex.alert_on_fan_pin = c[0];
				ex.alert_on_shared_pin = (s == 2);
				ex.overheat_on_dedicated_pin = c[1] && s != 1;
				ex.overheat_on_shared_pin = (s == 1);
				ex.volt_measure_on_dedicated_pin = !(c[1] && s != 1);
				chk("roles", 32'(ex), 32'(roles));
			end
		end
		host_u.write_reg(OFS_PIN_AND_TACH_CONFIG, 8'hF8);
		idle(3);
		chk("tach", 32'h1F, 32'({fast, steady}));
		// Boost needs the overheat input role and the boost bit together.
		sel = 2'h0;
		host_u.write_reg(OFS_PIN_AND_TACH_CONFIG, 8'h06);
		overheat = 1'b1;
		idle(8);
		chk("boost", 32'h1, 32'(full_duty));
		chk("timing", 32'h1, 32'(timing));
		host_u.write_reg(OFS_PIN_AND_TACH_CONFIG, 8'h02);
		idle(3);
		chk("no boost", 32'h0, 32'(full_duty));
		overheat = 1'b0;
		// Lock freezes the configuration only.
		lock = 1'b1;
		host_u.write_reg(OFS_PIN_AND_TACH_CONFIG, 8'hFF);
		host_u.write_reg(OFS_ALERT_MASK_SECOND, 8'h3C);
		rd(OFS_PIN_AND_TACH_CONFIG, 8'h02);
		rd(OFS_ALERT_MASK_SECOND, 8'h3C);
		idle(4);
		chk("pending reads", 32'h0, 32'(exp_q.size()));
		tally_and_finish();
	end
endmodule : tb
